// [hdl/can_mh_pkg.sv]
`default_nettype none
package can_mh_pkg;
   localparam int unsigned N_OBJ = 32;
   // register byte addresses
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_STATUS  = 8'h04;
   localparam logic [7:0] ADDR_INTERRUPT_IDENTIFIER   = 8'h08;
   localparam logic [7:0] ADDR_TIMING  = 8'h0c;
   localparam logic [7:0] ADDR_CMD_MSK = 8'h10;
   localparam logic [7:0] ADDR_CMD_REQ = 8'h14;
   localparam logic [7:0] ADDR_BUF_MSK = 8'h18;
   localparam logic [7:0] ADDR_BUF_ARB = 8'h1c;
   localparam logic [7:0] ADDR_BUF_CTL = 8'h20;
   localparam logic [7:0] ADDR_BUF_DLO = 8'h24;
   localparam logic [7:0] ADDR_BUF_DHI = 8'h28;
   // control word bits
   localparam int CTRL_IRQ_EN = 1;
   localparam int CTRL_SIE    = 2;
   localparam int CTRL_EIE    = 3;
   // command mask bits
   localparam int CM_WRITE  = 7;
   localparam int CM_MASK   = 6;
   localparam int CM_ARB    = 5;
   localparam int CM_CTRL   = 4;
   localparam int CM_CLRPND = 3;
   localparam int CM_TXND   = 2;
   localparam int CM_DATA_A = 1;
   localparam int CM_DATA_B = 0;
   localparam logic [7:0] CM_FULL_READ = 8'h7f;
   // buffer control / arbitration bits
   localparam int BC_NEW_DATA_FLAG = 15;
   localparam int BC_MESSAGE_LOST_FLAG = 14;
   localparam int BC_INT_PENDING_FLAG = 13;
   localparam int BC_UMASK  = 12;
   localparam int BC_RXIE   = 10;
   localparam int BC_TRANSMIT_REQUEST_FLAG = 8;
   localparam int BC_EOB    = 7;
   localparam int BA_MSGVAL = 31;
   localparam int BA_DIR    = 29;
   // timing word fields, each stored as value minus one
   localparam int BT_PRESC = 0;
   localparam int BT_SJW   = 8;
   localparam int BT_PRE   = 12;
   localparam int BT_POST  = 16;
   localparam int BT_PROP  = 20;
   localparam logic [31:0] BT_RESET   = 32'h00023301;
   localparam logic [15:0] INTERRUPT_IDENTIFIER_STAT = 16'h8000;
   localparam logic [15:0] INTERRUPT_IDENTIFIER_NONE = 16'h0000;

   typedef enum logic [1:0] {
      SEG_BIT_START, SEG_DELAY_COMP, SEG_PRE_SAMPLE, SEG_POST_SAMPLE
   } seg_e;

   typedef struct packed {
      logic        msgval;
      logic        dir;
      logic        umask;
      logic        end_of_block_flag;
      logic        rxie;
      logic        new_data_flag;
      logic        message_lost_flag;
      logic        int_pending_flag;
      logic        transmit_request_flag;
      logic [3:0]  dlc;
      logic [28:0] id;
      logic [28:0] mask;
      logic [63:0] data;
   } obj_s;

   typedef struct packed {
      logic        valid;
      logic [28:0] id;
      logic [3:0]  dlc;
      logic [63:0] data;
   } rx_frame_s;

   typedef struct packed {
      logic       valid;
      logic       is_error;
      logic       rx_success_flag;
      logic       tx_success_flag;
      logic [2:0] last_error_code;
   } stat_upd_s;

   typedef struct packed {
      logic        valid;
      logic [5:0]  obj;
      logic [28:0] id;
   } rf_req_s;
endpackage : can_mh_pkg
`default_nettype wire

// [hdl/can_rx_fifo_irq_bit_timing.sv]
`default_nettype none
// Notes on behaviour
// - full mask then number fetches, clears flags
// - masked objects keep the received identifier
// - new data and lost flags track receptions
// - request flag on receive object sends remote
// - matching data frame drops pending remote request
// - store into lowest free matching member
// - filled non-last member locked until released
// - no release means last member is overwritten
// - buffer shows flags before they were cleared
// - identifier shows top pending, held until cleared
// - status first, then lower object numbers
// - pending clear or status read drops interrupt
// - zero when idle; line follows identifier, enable
// - 0x8000 means status; cpu writes raise none
// - status enables gate; status bits update regardless
// - clear-on-read clears pending, identifier advances
// - quantum is prescaler over clock, 1 to 32
// - bit is start, delay, pre, post slots
// - resync lengthens pre or shortens post slot
// - jump width 1 to 4, not over slots
module can_rx_fifo_irq_bit_timing
(
   // clock and reset
   input  wire logic                  i_mclk,
   input  wire logic                  i_rst,
   // register port
   input  wire logic [7:0]            i_addr,
   input  wire logic [31:0]           i_wdata,
   input  wire logic                  i_wr,
   input  wire logic                  i_rd,
   output logic      [31:0]           o_rdata,
   // protocol core side
   input  wire can_mh_pkg::rx_frame_s i_rx,
   input  wire can_mh_pkg::stat_upd_s i_stat,
   output can_mh_pkg::rf_req_s        o_rf,
   input  wire logic                  i_rf_done,
   input  wire logic                  i_can_rx,
   output logic                       o_tq_tick,
   output logic                       o_bit_start,
   output logic                       o_sample,
   // interrupt line
   output logic                       o_cpu_irq
);
   typedef struct packed {
      can_mh_pkg::obj_s [can_mh_pkg::N_OBJ-1:0] objs;
      logic [31:0]       ctrl;
      logic [4:0]        status;
      logic              stat_int;
      logic [31:0]       timing;
      logic [7:0]        cmd_mask;
      logic [31:0]       buf_mask;
      logic [31:0]       buf_arb;
      logic [31:0]       buf_ctl;
      logic [63:0]       buf_data;
      logic [15:0]       interrupt_identifier;
      logic              irq;
      logic [31:0]       rdata;
      can_mh_pkg::rf_req_s rf;
      can_mh_pkg::seg_e  seg;
      logic [4:0]        presc_cnt;
      logic [3:0]        q_cnt;
      logic [3:0]        seg_len;
      logic [4:0]        qpos;
      logic              resynced;
      logic              can_prev;
      logic              tq_tick;
      logic              bit_start;
      logic              sample;
   } state_s;

   state_s s_r;
   state_s s_nxt;

   // lowest set bit as index plus found flag
   function automatic logic [6:0] lowest(
      input logic [can_mh_pkg::N_OBJ-1:0] v);
      logic [6:0] r;
      r = '0;
      for (int k = can_mh_pkg::N_OBJ - 1; k >= 0; k--)
      begin
         if (v[k])
            r = {1'b1, k[5:0]};
      end
      return r;
   endfunction : lowest

   logic [can_mh_pkg::N_OBJ-1:0] rx_ok_v;
   logic [can_mh_pkg::N_OBJ-1:0] pend_v;
   logic [can_mh_pkg::N_OBJ-1:0] rtr_v;
   logic [6:0]  rx_tgt;
   logic [6:0]  pend_top;
   logic [6:0]  rtr_top;
   logic [5:0]  req_idx;
   logic        req_ok;
   logic [3:0]  pre_len;
   logic [3:0]  post_len;
   logic [3:0]  delay_len;
   logic [3:0]  sjw_len;
   logic [3:0]  err;
   logic [3:0]  jump;
   logic        edge_seen;
   logic        st_rd;

   assign req_idx = 6'(i_wdata[5:0] - 6'h01);
   assign req_ok  = (i_wdata[5:0] != 6'h00) && (i_wdata[6:0] <= 7'h20);
   assign st_rd   = i_rd && (i_addr == can_mh_pkg::ADDR_STATUS);

   // acceptance and priority vectors
   generate
      for (genvar g = 0; g < can_mh_pkg::N_OBJ; g++)
      begin : g_obj
         logic [28:0] cmp;
         assign cmp = s_r.objs[g].umask ? s_r.objs[g].mask : '1;
         // a filled non-last member is skipped, the last never is
         assign rx_ok_v[g] = s_r.objs[g].msgval && !s_r.objs[g].dir
            && (((s_r.objs[g].id ^ i_rx.id) & cmp) == 29'h0)
            && !(s_r.objs[g].new_data_flag && !s_r.objs[g].end_of_block_flag);
         assign pend_v[g] = s_r.objs[g].int_pending_flag;
         assign rtr_v[g]  = s_r.objs[g].transmit_request_flag
            && s_r.objs[g].msgval && !s_r.objs[g].dir;
      end
   endgenerate

   assign rx_tgt   = lowest(rx_ok_v);
   assign pend_top = lowest(pend_v);
   assign rtr_top  = lowest(rtr_v);

   assign pre_len   = 4'(s_r.timing[can_mh_pkg::BT_PRE +: 3]) + 4'h1;
   assign post_len  = 4'(s_r.timing[can_mh_pkg::BT_POST +: 3]) + 4'h1;
   assign delay_len = 4'(s_r.timing[can_mh_pkg::BT_PROP +: 3]) + 4'h1;
   assign sjw_len   = 4'(s_r.timing[can_mh_pkg::BT_SJW +: 2]) + 4'h1;
   assign edge_seen = s_r.can_prev && !i_can_rx && !s_r.resynced;
   // phase error: late edges count from bit start, early ones to bit end
   assign err  = (s_r.seg == can_mh_pkg::SEG_POST_SAMPLE)
               ? 4'(s_r.seg_len - s_r.q_cnt) : s_r.qpos[3:0];
   assign jump = (err < sjw_len) ? err : sjw_len;

   always_comb
   begin
      int unsigned n;
      logic [can_mh_pkg::N_OBJ-1:0] pv;
      logic [6:0] top;
      n = 0;
      pv = '0;
      top = '0;
      s_nxt          = s_r;
      s_nxt.tq_tick   = 1'b0;
      s_nxt.bit_start = 1'b0;
      s_nxt.sample    = 1'b0;
      s_nxt.rdata     = '0;
      s_nxt.can_prev  = i_can_rx;

      // register reads, data stand one cycle later
      if (i_rd)
      begin
         case (i_addr)
            can_mh_pkg::ADDR_CTRL:    s_nxt.rdata = s_r.ctrl;
            can_mh_pkg::ADDR_STATUS:  s_nxt.rdata = 32'(s_r.status);
            can_mh_pkg::ADDR_INTERRUPT_IDENTIFIER:   s_nxt.rdata = 32'(s_r.interrupt_identifier);
            can_mh_pkg::ADDR_TIMING:  s_nxt.rdata = s_r.timing;
            can_mh_pkg::ADDR_CMD_MSK: s_nxt.rdata = 32'(s_r.cmd_mask);
            can_mh_pkg::ADDR_BUF_MSK: s_nxt.rdata = s_r.buf_mask;
            can_mh_pkg::ADDR_BUF_ARB: s_nxt.rdata = s_r.buf_arb;
            can_mh_pkg::ADDR_BUF_CTL: s_nxt.rdata = s_r.buf_ctl;
            can_mh_pkg::ADDR_BUF_DLO: s_nxt.rdata = s_r.buf_data[31:0];
            can_mh_pkg::ADDR_BUF_DHI: s_nxt.rdata = s_r.buf_data[63:32];
            default:                  s_nxt.rdata = '0;
         endcase
      end

      // status interrupt: reading clears, a core update in the same
      // cycle wins; cpu writes to the status bits leave it alone
      if (st_rd)
         s_nxt.stat_int = 1'b0;
      if (i_wr)
      begin
         case (i_addr)
            can_mh_pkg::ADDR_CTRL:    s_nxt.ctrl = i_wdata;
            can_mh_pkg::ADDR_STATUS:  s_nxt.status = i_wdata[4:0];
            can_mh_pkg::ADDR_TIMING:  s_nxt.timing = i_wdata;
            can_mh_pkg::ADDR_CMD_MSK: s_nxt.cmd_mask = i_wdata[7:0];
            can_mh_pkg::ADDR_BUF_MSK: s_nxt.buf_mask = i_wdata;
            can_mh_pkg::ADDR_BUF_ARB: s_nxt.buf_arb = i_wdata;
            can_mh_pkg::ADDR_BUF_CTL: s_nxt.buf_ctl = i_wdata;
            can_mh_pkg::ADDR_BUF_DLO: s_nxt.buf_data[31:0] = i_wdata;
            can_mh_pkg::ADDR_BUF_DHI: s_nxt.buf_data[63:32] = i_wdata;
            default: ;
         endcase
      end
      if (i_stat.valid)
      begin
         s_nxt.status = {i_stat.rx_success_flag, i_stat.tx_success_flag,
                         i_stat.last_error_code};
         if (i_stat.is_error ? s_r.ctrl[can_mh_pkg::CTRL_EIE]
                             : s_r.ctrl[can_mh_pkg::CTRL_SIE])
            s_nxt.stat_int = 1'b1;
      end

      // remote request handshake with the protocol core; done comes
      // first so a cpu request in the same cycle is kept as a new one
      if (i_rf_done && s_r.rf.valid)
         s_nxt.objs[s_r.rf.obj[4:0]].transmit_request_flag = 1'b0;

      // command request: transfer between buffer and object
      if (i_wr && (i_addr == can_mh_pkg::ADDR_CMD_REQ) && req_ok)
      begin
         n = int'(req_idx);
         if (s_r.cmd_mask[can_mh_pkg::CM_WRITE])
         begin
            if (s_r.cmd_mask[can_mh_pkg::CM_MASK])
               s_nxt.objs[n].mask = s_r.buf_mask[28:0];
            if (s_r.cmd_mask[can_mh_pkg::CM_ARB])
            begin
               s_nxt.objs[n].id     = s_r.buf_arb[28:0];
               s_nxt.objs[n].dir    = s_r.buf_arb[can_mh_pkg::BA_DIR];
               s_nxt.objs[n].msgval = s_r.buf_arb[can_mh_pkg::BA_MSGVAL];
            end
            if (s_r.cmd_mask[can_mh_pkg::CM_CTRL])
            begin
               s_nxt.objs[n].new_data_flag =
                  s_r.buf_ctl[can_mh_pkg::BC_NEW_DATA_FLAG];
               s_nxt.objs[n].message_lost_flag =
                  s_r.buf_ctl[can_mh_pkg::BC_MESSAGE_LOST_FLAG];
               s_nxt.objs[n].int_pending_flag =
                  s_r.buf_ctl[can_mh_pkg::BC_INT_PENDING_FLAG];
               s_nxt.objs[n].umask = s_r.buf_ctl[can_mh_pkg::BC_UMASK];
               s_nxt.objs[n].rxie  = s_r.buf_ctl[can_mh_pkg::BC_RXIE];
               s_nxt.objs[n].end_of_block_flag   = s_r.buf_ctl[can_mh_pkg::BC_EOB];
               s_nxt.objs[n].transmit_request_flag =
                  s_r.buf_ctl[can_mh_pkg::BC_TRANSMIT_REQUEST_FLAG];
               s_nxt.objs[n].dlc = s_r.buf_ctl[3:0];
            end
            if (s_r.cmd_mask[can_mh_pkg::CM_TXND])
               s_nxt.objs[n].transmit_request_flag = 1'b1;
            if (s_r.cmd_mask[can_mh_pkg::CM_DATA_A])
               s_nxt.objs[n].data[31:0] = s_r.buf_data[31:0];
            if (s_r.cmd_mask[can_mh_pkg::CM_DATA_B])
               s_nxt.objs[n].data[63:32] = s_r.buf_data[63:32];
         end
         else
         begin
            // buffer gets the flags as they stood before the clear
            if (s_r.cmd_mask[can_mh_pkg::CM_MASK])
               s_nxt.buf_mask = {3'h0, s_r.objs[n].mask};
            if (s_r.cmd_mask[can_mh_pkg::CM_ARB])
               s_nxt.buf_arb = {s_r.objs[n].msgval, 1'b0,
                                s_r.objs[n].dir, s_r.objs[n].id};
            if (s_r.cmd_mask[can_mh_pkg::CM_CTRL])
               s_nxt.buf_ctl = {16'h0,
                  s_r.objs[n].new_data_flag, s_r.objs[n].message_lost_flag,
                  s_r.objs[n].int_pending_flag, s_r.objs[n].umask, 1'b0,
                  s_r.objs[n].rxie, 1'b0, s_r.objs[n].transmit_request_flag,
                  s_r.objs[n].end_of_block_flag, 3'h0, s_r.objs[n].dlc};
            if (s_r.cmd_mask[can_mh_pkg::CM_DATA_A])
               s_nxt.buf_data[31:0] = s_r.objs[n].data[31:0];
            if (s_r.cmd_mask[can_mh_pkg::CM_DATA_B])
               s_nxt.buf_data[63:32] = s_r.objs[n].data[63:32];
            if (s_r.cmd_mask[can_mh_pkg::CM_TXND])
               s_nxt.objs[n].new_data_flag = 1'b0;
            if (s_r.cmd_mask[can_mh_pkg::CM_CLRPND])
               s_nxt.objs[n].int_pending_flag = 1'b0;
         end
      end

      // reception comes last so its flag sets win over cpu clears
      if (i_rx.valid && rx_tgt[6])
      begin
         n = int'(rx_tgt[5:0]);
         s_nxt.objs[n].id   = i_rx.id;
         s_nxt.objs[n].dlc  = i_rx.dlc;
         s_nxt.objs[n].data = i_rx.data;
         if (s_r.objs[n].new_data_flag)
            s_nxt.objs[n].message_lost_flag = 1'b1;
         s_nxt.objs[n].new_data_flag = 1'b1;
         if (s_r.objs[n].rxie)
            s_nxt.objs[n].int_pending_flag = 1'b1;
         s_nxt.objs[n].transmit_request_flag = 1'b0;
      end

      // request stays up until the core takes it
      if (!s_r.rf.valid || i_rf_done)
      begin
         s_nxt.rf.valid = rtr_top[6];
         s_nxt.rf.obj   = rtr_top[5:0];
         s_nxt.rf.id    = s_r.objs[rtr_top[4:0]].id;
      end

      // identifier and line from the updated pending state
      begin
         for (int k = 0; k < can_mh_pkg::N_OBJ; k++)
            pv[k] = s_nxt.objs[k].int_pending_flag;
         top = lowest(pv);
         if (s_nxt.stat_int)
            s_nxt.interrupt_identifier = can_mh_pkg::INTERRUPT_IDENTIFIER_STAT;
         else if (top[6])
            s_nxt.interrupt_identifier = 16'(top[5:0]) + 16'h0001;
         else
            s_nxt.interrupt_identifier = can_mh_pkg::INTERRUPT_IDENTIFIER_NONE;
         s_nxt.irq = (s_nxt.interrupt_identifier != can_mh_pkg::INTERRUPT_IDENTIFIER_NONE)
                  && s_nxt.ctrl[can_mh_pkg::CTRL_IRQ_EN];
      end

      // quantum divider, one tick per prescaler count
      if (s_r.presc_cnt >= s_r.timing[can_mh_pkg::BT_PRESC +: 5])
      begin
         s_nxt.presc_cnt = '0;
         s_nxt.tq_tick   = 1'b1;
      end
      else
         s_nxt.presc_cnt = 5'(s_r.presc_cnt + 5'h01);

      // hard sync is out of scope; one resync per bit
      if (edge_seen && (s_r.seg != can_mh_pkg::SEG_BIT_START))
      begin
         s_nxt.resynced = 1'b1;
         if (s_r.seg == can_mh_pkg::SEG_POST_SAMPLE)
            s_nxt.seg_len = 4'(s_r.seg_len - jump);
         else
            s_nxt.seg_len = 4'(s_r.seg_len + jump);
      end

      if (s_r.tq_tick)
      begin
         s_nxt.qpos  = 5'(s_r.qpos + 5'h01);
         s_nxt.q_cnt = 4'(s_r.q_cnt + 4'h1);
         if (s_nxt.q_cnt >= s_nxt.seg_len)
         begin
            s_nxt.q_cnt = '0;
            case (s_r.seg)
               can_mh_pkg::SEG_BIT_START:
               begin
                  s_nxt.seg     = can_mh_pkg::SEG_DELAY_COMP;
                  s_nxt.seg_len = delay_len;
               end
               can_mh_pkg::SEG_DELAY_COMP:
               begin
                  s_nxt.seg = can_mh_pkg::SEG_PRE_SAMPLE;
                  // a late edge in the delay slot moves into pre slot
                  s_nxt.seg_len = 4'(pre_len + s_nxt.seg_len - delay_len);
               end
               can_mh_pkg::SEG_PRE_SAMPLE:
               begin
                  s_nxt.seg     = can_mh_pkg::SEG_POST_SAMPLE;
                  s_nxt.seg_len = post_len;
                  s_nxt.sample  = 1'b1;
               end
               default:
               begin
                  s_nxt.seg       = can_mh_pkg::SEG_BIT_START;
                  s_nxt.seg_len   = 4'h1;
                  s_nxt.qpos      = '0;
                  s_nxt.resynced  = 1'b0;
                  s_nxt.bit_start = 1'b1;
               end
            endcase
         end
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         s_r        <= '0;
         s_r.timing <= can_mh_pkg::BT_RESET;
         s_r.seg    <= can_mh_pkg::SEG_BIT_START;
         s_r.seg_len <= 4'h1;
         s_r.can_prev <= 1'b1;
      end
      else
         s_r <= s_nxt;
   end

   assign o_rdata     = s_r.rdata;
   assign o_rf        = s_r.rf;
   assign o_tq_tick   = s_r.tq_tick;
   assign o_bit_start = s_r.bit_start;
   assign o_sample    = s_r.sample;
   assign o_cpu_irq   = s_r.irq;

   // checks
   logic [5:0] tq_gap;
   logic       tq_dirty;
   always_ff @(posedge i_mclk)
   begin
      if (i_rst || s_r.tq_tick)
         tq_gap <= '0;
      else
         tq_gap <= 6'(tq_gap + 6'h01);
      // a period cut by reset or a timing write has no fixed length
      tq_dirty <= i_rst || (s_nxt.timing != s_r.timing)
                  || (tq_dirty && !s_r.tq_tick);
   end

   sequence s_full_fetch;
      i_wr && (i_addr == can_mh_pkg::ADDR_CMD_REQ) && req_ok
      && (s_r.cmd_mask == can_mh_pkg::CM_FULL_READ) && !i_rx.valid;
   endsequence
   sequence s_start_tick;
      (s_r.seg == can_mh_pkg::SEG_BIT_START) && s_r.tq_tick;
   endsequence

   a_fetch_clears: assert property (@(posedge i_mclk) disable iff (i_rst)
      s_full_fetch |=> !s_r.objs[$past(req_idx)].new_data_flag
                       && !s_r.objs[$past(req_idx)].int_pending_flag)
      else $error("fetch did not clear flags");
   a_buf_old_flags: assert property (@(posedge i_mclk) disable iff (i_rst)
      s_full_fetch |=> s_r.buf_ctl[can_mh_pkg::BC_NEW_DATA_FLAG]
                       == $past(s_r.objs[req_idx].new_data_flag))
      else $error("buffer flags not pre-clear values");
   a_lost_on_second: assert property (@(posedge i_mclk) disable iff (i_rst)
      (i_rx.valid && rx_tgt[6] && s_r.objs[rx_tgt[5:0]].new_data_flag)
      |=> s_r.objs[$past(rx_tgt[5:0])].message_lost_flag)
      else $error("lost flag not set");
   a_rx_drops_rtr: assert property (@(posedge i_mclk) disable iff (i_rst)
      (i_rx.valid && rx_tgt[6])
      |=> !s_r.objs[$past(rx_tgt[5:0])].transmit_request_flag)
      else $error("request flag survived reception");
   a_fifo_lock: assert property (@(posedge i_mclk) disable iff (i_rst)
      (i_rx.valid && rx_tgt[6]) |-> !(s_r.objs[rx_tgt[5:0]].new_data_flag
                                     && !s_r.objs[rx_tgt[5:0]].end_of_block_flag))
      else $error("locked member written");
   a_status_first: assert property (@(posedge i_mclk) disable iff (i_rst)
      s_r.stat_int |-> s_r.interrupt_identifier == can_mh_pkg::INTERRUPT_IDENTIFIER_STAT)
      else $error("status not top priority");
   a_irq_follows: assert property (@(posedge i_mclk) disable iff (i_rst)
      o_cpu_irq == ((s_r.interrupt_identifier != can_mh_pkg::INTERRUPT_IDENTIFIER_NONE)
                    && s_r.ctrl[can_mh_pkg::CTRL_IRQ_EN]))
      else $error("line does not follow identifier");
   a_cpu_no_raise: assert property (@(posedge i_mclk) disable iff (i_rst)
      (i_wr && !i_stat.valid && !s_r.stat_int) |=> !s_r.stat_int)
      else $error("cpu write raised status interrupt");
   a_tq_period: assert property (@(posedge i_mclk) disable iff (i_rst)
      (s_r.tq_tick && !tq_dirty && tq_gap != 6'h00)
      |-> tq_gap == 6'(s_r.timing[can_mh_pkg::BT_PRESC +: 5]))
      else $error("quantum length wrong");
   a_start_slot: assert property (@(posedge i_mclk) disable iff (i_rst)
      s_start_tick |=> s_r.seg == can_mh_pkg::SEG_DELAY_COMP)
      else $error("start slot not one quantum");
endmodule : can_rx_fifo_irq_bit_timing
`default_nettype wire

// [verif/can_core_model.sv]
`default_nettype none
// stands in for the protocol core and the other nodes on the bus
module can_core_model
#(
   parameter int ACK_WAIT = 5
)
(
   input  wire logic                 i_mclk,
   input  wire can_mh_pkg::rf_req_s  i_rf,
   output var  can_mh_pkg::rx_frame_s o_rx,
   output var  can_mh_pkg::stat_upd_s o_stat,
   output var  logic                 o_rf_done,
   output var  logic                 o_can_rx
);
   timeunit 1ns;
   timeprecision 1ps;
   int wait_cnt = 0;
   initial
   begin
      o_rx = '0;
      o_stat = '0;
      o_rf_done = 1'b0;
      o_can_rx = 1'b1;
   end
   // payload is scrambled outside the valid pulse so nothing leans on it
   task send(logic [28:0] id, logic [63:0] d);
      @(posedge i_mclk);
      o_rx <= '{1'b1, id, 4'h8, d};
      @(posedge i_mclk);
      o_rx <= '{1'b0, ~id, 4'h7, ~d};
   endtask : send
   task stat(logic err);
      @(posedge i_mclk);
      o_stat <= '{1'b1, err, 1'b1, 1'b0, 3'h0};
      @(posedge i_mclk);
      o_stat <= '{1'b0, ~err, 1'b0, 1'b1, 3'h5};
   endtask : stat
   // one dominant cycle gives a single falling edge on the bus
   task dip;
      @(posedge i_mclk);
      o_can_rx <= 1'b0;
      @(posedge i_mclk);
      o_can_rx <= 1'b1;
   endtask : dip
   // remote frame goes out after a bus delay, then done pulses
   always @(posedge i_mclk)
   begin
      o_rf_done <= 1'b0;
      wait_cnt <= i_rf.valid && !o_rf_done ? wait_cnt + 1 : 0;
      if (i_rf.valid && !o_rf_done && wait_cnt == ACK_WAIT)
         o_rf_done <= 1'b1;
   end
endmodule : can_core_model
`default_nettype wire

// [verif/can_rx_fifo_irq_bit_timing_tb.sv]
`default_nettype none
module can_rx_fifo_irq_bit_timing_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [7:0] a; logic [31:0] w, e;} row_s;
   logic                  i_mclk = 0, i_rst = 1, i_wr = 0, i_rd = 0;
   logic [7:0]            i_addr = '0;
   logic [31:0]           i_wdata = '0, o_rdata;
   can_mh_pkg::rx_frame_s rx;
   can_mh_pkg::stat_upd_s st;
   can_mh_pkg::rf_req_s   rf;
   logic                  rf_done, can_rx, bs, irq, tq, smp;
   int                    fails = 0, check_count = 0, n, m, q;
   row_s rows [4] = '{'{8'h0c, 32'h0077731f, 32'h0077731f},
      '{8'h14, 32'h0, 32'h0}, '{8'h40, 32'hffffffff, 32'h0},
      '{8'h0c, 32'h00023301, 32'h00023301}};
   can_rx_fifo_irq_bit_timing dut_u (.i_mclk(i_mclk), .i_rst(i_rst),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .i_rx(rx), .i_stat(st), .o_rf(rf),
      .i_rf_done(rf_done), .i_can_rx(can_rx), .o_tq_tick(tq),
      .o_bit_start(bs), .o_sample(smp), .o_cpu_irq(irq));
   can_core_model #(.ACK_WAIT(40)) core_u (.i_mclk(i_mclk), .i_rf(rf),
      .o_rx(rx), .o_stat(st), .o_rf_done(rf_done), .o_can_rx(can_rx));
   initial
   begin
      forever #2 i_mclk = ~i_mclk;
   end
   task test_done;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done
   task check(string nm, logic [34:0] seen, logic [34:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task tick;
      @(posedge i_mclk);
      #1;
   endtask : tick
   task wr(logic [7:0] a, logic [31:0] d);
      @(posedge i_mclk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask : wr
   task rd(logic [7:0] a, logic [31:0] e, string nm);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1;
      check(nm, o_rdata, e);
   endtask : rd
   task obj(logic [5:0] k, logic [28:0] id, logic [15:0] c, logic [7:0] m);
      wr(can_mh_pkg::ADDR_BUF_ARB, {3'b100, id});
      wr(can_mh_pkg::ADDR_BUF_CTL, {16'h0, c});
      wr(can_mh_pkg::ADDR_CMD_MSK, {24'h0, m});
      wr(can_mh_pkg::ADDR_CMD_REQ, {26'h0, k});
   endtask : obj
   task fetch(logic [5:0] k);
      wr(can_mh_pkg::ADDR_CMD_MSK, {24'h0, can_mh_pkg::CM_FULL_READ});
      wr(can_mh_pkg::ADDR_CMD_REQ, {26'h0, k});
   endtask : fetch
   initial
   begin
      repeat (5000) @(posedge i_mclk);
      fails++;
      test_done();
   end
   initial
   begin
      repeat (16) @(posedge i_mclk);
      i_rst <= 1'b0;
      rd(can_mh_pkg::ADDR_TIMING, can_mh_pkg::BT_RESET, "timing reset");
      rd(can_mh_pkg::ADDR_INTERRUPT_IDENTIFIER, 32'h0, "interrupt_identifier reset");
      while (bs !== 1'b1) tick();
      n = 0;
      m = 0;
      q = 0;
      // reset timing: 2 clocks a quantum, slots 1, 1, 4 and 3 quanta
      do
      begin
         tick();
         n++;
         if (tq === 1'b1)
            q++;
         if (smp === 1'b1)
            m = n;
      end while (bs !== 1'b1 && n < 99);
      check("bit length", n, 32'h12);
      check("sample point", m, 32'h0c);
      check("quanta per bit", q, 32'h09);
      while (bs !== 1'b1) tick();
      // edge five quanta in, late in pre slot: jump capped at four
      repeat (9) tick();
      core_u.dip();
      n = 0;
      do
      begin
         tick();
         n++;
      end while (bs !== 1'b1 && n < 99);
      check("resync", n, 32'h0f);
      $display("test reset and bit time done");
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, rows[i].e, "register row");
      end
      $display("test registers done");
      wr(can_mh_pkg::ADDR_CTRL, 32'h2);
      obj(1, 29'h123, 16'h0400, 8'hf0);
      obj(2, 29'h123, 16'h0480, 8'hf0);
      core_u.send(29'h123, 64'h11);
      core_u.send(29'h123, 64'h22);
      core_u.send(29'h123, 64'h33);
      tick();
      rd(can_mh_pkg::ADDR_INTERRUPT_IDENTIFIER, 32'h1, "head first");
      check("line on", irq, 1);
      fetch(1);
      rd(can_mh_pkg::ADDR_BUF_CTL, 32'ha408, "head ctl");
      rd(can_mh_pkg::ADDR_BUF_DLO, 32'h11, "head data");
      rd(can_mh_pkg::ADDR_INTERRUPT_IDENTIFIER, 32'h2, "next pending");
      fetch(2);
      rd(can_mh_pkg::ADDR_BUF_CTL, 32'he488, "tail ctl");
      rd(can_mh_pkg::ADDR_BUF_DLO, 32'h33, "tail data");
      rd(can_mh_pkg::ADDR_INTERRUPT_IDENTIFIER, 32'h0, "none left");
      check("line off", irq, 0);
      fetch(2);
      rd(can_mh_pkg::ADDR_BUF_CTL, 32'h4488, "lost sticks");
      $display("test fifo done");
      wr(can_mh_pkg::ADDR_CTRL, 32'h4);
      core_u.stat(1'b0);
      tick();
      rd(can_mh_pkg::ADDR_INTERRUPT_IDENTIFIER, 32'h8000, "status irq");
      check("line masked", irq, 0);
      rd(can_mh_pkg::ADDR_STATUS, 32'h10, "status bits");
      rd(can_mh_pkg::ADDR_INTERRUPT_IDENTIFIER, 32'h0, "status read");
      core_u.stat(1'b1);
      wr(can_mh_pkg::ADDR_STATUS, 32'h1f);
      rd(can_mh_pkg::ADDR_INTERRUPT_IDENTIFIER, 32'h0, "gated");
      $display("test status done");
      obj(3, 29'h55, 16'h0080, 8'hf4);
      n = 0;
      while (rf.valid !== 1'b1 && n < 20)
      begin
         tick();
         n++;
      end
      check("remote", {rf.obj, rf.id}, {6'd2, 29'h55});
      core_u.send(29'h55, 64'h0);
      fetch(3);
      rd(can_mh_pkg::ADDR_BUF_CTL, 32'h8088, "request dropped");
      obj(5, 29'h0, 16'h1080, 8'hf0);
      core_u.send(29'h7a5, 64'h0);
      fetch(5);
      rd(can_mh_pkg::ADDR_BUF_ARB, 32'h800007a5, "stored id");
      $display("test remote and mask done");
      test_done();
   end
endmodule : can_rx_fifo_irq_bit_timing_tb
`default_nettype wire
